// ---- pkg/tdes_pkg.sv ----
// package for the transmit descriptor error status block
package tdes_pkg;
	// status word field positions
	localparam int CBE_BIT   = 15;
	localparam int FSE_BIT   = 14;
	localparam int RSV_BIT   = 13;
	localparam int LATE_COLLISION_FLAG_BIT  = 12;
	localparam int CARRIER_LOSS_FLAG_BIT  = 11;
	localparam int RTX_BIT   = 10;
	localparam int FD_MSB    = 9;
	localparam int FD_W      = 10;
	// retry budget
	localparam int RETRY_MAX = 16;
	localparam int TRY_W     = 5;
	// reset values
	localparam logic [15:0] STATUS_RST = 16'h0000;
	localparam logic [FD_W-1:0] FD_RST = 10'h000;
	localparam logic [TRY_W-1:0] TRY_RST = 5'h00;

	// events seen on the wire and in the fifo during one frame
	typedef struct packed {
		logic start;     // start of a transmit attempt
		logic collision; // collision during the attempt
		logic late;      // slot time elapsed when collision hit
		logic done;      // frame fully sent, no collision
	} tdes_attempt_t;

	// buffer chain state from the descriptor engine
	typedef struct packed {
		logic end_of_packet_flag; // current buffer is final
		logic next_owned;         // lookahead saw next descriptor owned
		logic lookahead_done;     // lookahead poll has completed
		logic fifo_empty;         // transmit fifo ran dry
	} tdes_chain_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ATTEMPT,
		ST_BACKOFF,
		ST_FINISH
	} tdes_state_t;
endpackage : tdes_pkg

// ---- rtl/tdes_status.sv ----
// transmit error status word logic for one frame
`timescale 1ns/100ps
`default_nettype none
module tdes_status
	import tdes_pkg::*;
#(
	parameter int RETRIES = RETRY_MAX
) (
	// clock and reset
	input  wire logic          CORE_CLK,
	input  wire logic          RST_B,
	// control
	input  wire logic          TX_ENABLE,
	input  wire logic          RETRY_DISABLE,
	input  wire logic          FRAME_REQ,
	// attempt and chain events
	input  wire tdes_attempt_t ATTEMPT,
	input  wire tdes_chain_t   CHAIN,
	input  wire logic          RECEIVE_CARRIER_INPUT,
	// status outputs
	output logic               TRANSMITTER_ON,
	output logic               RETRY_REQ,
	output logic               ABORT_FRAME,
	output logic [15:0]        TX_ERROR_STATUS_WORD,
	output logic               STATUS_WRITE,
	output logic               FRAME_DONE
);

	// sequencer, counters and status word, each as a next value and its flop
	tdes_state_t          state_q, state_d;
	logic                 transmitter_on_q, transmitter_on_d;
	logic [15:0]          word_q, word_d;
	logic [FD_W-1:0]      fd_q, fd_d;
	logic [TRY_W-1:0]     tries_q, tries_d;
	logic                 wr_q, wr_d;
	logic                 done_q, done_d;
	logic                 retry_q, retry_d;
	logic                 abort_q, abort_d;
	// decoded conditions shared by the groups below
	logic                 chain_break;
	logic                 starve;
	logic                 retry_spent;
	logic                 in_idle;
	logic                 in_backoff;
	logic                 in_attempt;
	logic                 in_finish;
	logic                 take_frame;
	logic                 take_start;
	logic                 hit_coll;
	logic                 end_starve;
	logic                 end_late;
	logic                 end_spent;
	logic                 end_clean;
	logic                 do_retry;

	// chain break: not the last buffer, and the next one is not ours, either
	// because the lookahead found it unowned or because the fifo ran dry first
	function automatic logic chain_break_f(input tdes_chain_t c);
		logic unowned;
		logic early_dry;
		unowned   = c.lookahead_done && !c.next_owned;
		early_dry = c.fifo_empty && !c.lookahead_done;
		return !c.end_of_packet_flag && (unowned || early_dry);
	endfunction

	// starve: the fifo ran dry before the end of the frame; a chain break
	// always counts as one, so the host never sees the break on its own
	function automatic logic starve_f(input tdes_chain_t c, input logic brk);
		return c.fifo_empty || brk;
	endfunction

	// retry budget: with retries disabled one failed attempt uses it up;
	// a budget above the counter's range would be cut, so keep it below 32
	function automatic logic retry_spent_f(input logic [TRY_W-1:0] n, input logic no_retry);
		return no_retry || (n >= TRY_W'(RETRIES));
	endfunction

	// saturating step of the fault distance counter: a stuck top value is
	// safer than a wrap, which would report a near fault on a long frame
	function automatic logic [FD_W-1:0] fd_step_f(input logic [FD_W-1:0] v);
		logic [FD_W-1:0] top;
		top = {FD_W{1'h1}};
		if (v == top) begin
			return v;
		end
		return v + {{(FD_W-1){1'h0}}, 1'h1};
	endfunction

	// error summary over the flag bits; a fault distance alone is no error
	function automatic logic err_any_f(input logic [15:0] w);
		return |w[CBE_BIT:RTX_BIT];
	endfunction

	// chain view and starve are levels, judged only while an attempt runs
	assign chain_break = chain_break_f(CHAIN);
	assign starve      = starve_f(CHAIN, chain_break);
	assign retry_spent = retry_spent_f(tries_q, RETRY_DISABLE);

	// state decodes
	assign in_idle    = (state_q == ST_IDLE);
	assign in_backoff = (state_q == ST_BACKOFF);
	assign in_attempt = (state_q == ST_ATTEMPT);
	assign in_finish  = (state_q == ST_FINISH);

	// requests are taken only in their own state, and a frame only while on
	assign take_frame = in_idle && FRAME_REQ && transmitter_on_q;
	assign take_start = in_backoff && ATTEMPT.start;

	// attempt outcomes, by priority: starve, late collision, collision, done
	assign end_starve = in_attempt && starve;
	assign end_late   = in_attempt && !starve && ATTEMPT.collision && ATTEMPT.late;
	assign hit_coll   = in_attempt && !starve && ATTEMPT.collision && !ATTEMPT.late;
	assign end_spent  = hit_coll && retry_spent;
	assign do_retry   = hit_coll && !retry_spent;
	assign end_clean  = in_attempt && !starve && !ATTEMPT.collision && ATTEMPT.done;

	// next state of the frame sequencer
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (take_frame) begin
					state_d = ST_BACKOFF;
				end
			end
			ST_BACKOFF: begin
				if (take_start) begin
					state_d = ST_ATTEMPT;
				end
			end
			ST_ATTEMPT: begin
				// late collision, starve and spent budget never go back to
				// backoff; carrier loss does not end the frame at all
				if (end_starve || end_late || end_spent || end_clean) begin
					state_d = ST_FINISH;
				end else if (do_retry) begin
					state_d = ST_BACKOFF;
				end
			end
			ST_FINISH: begin
				state_d = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// register the sequencer state
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// attempt counter: restarts with each frame, counts every attempt begun
	always_comb begin
		tries_d = tries_q;
		if (take_frame) begin
			tries_d = TRY_RST;
		end else if (take_start) begin
			tries_d = tries_q + {{(TRY_W-1){1'h0}}, 1'h1};
		end
	end

	// register the attempt counter
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			tries_q <= TRY_RST;
		end else begin
			tries_q <= tries_d;
		end
	end

	// fault distance: cleared as an attempt starts, then one step a cycle
	always_comb begin
		fd_d = fd_q;
		if (take_start) begin
			fd_d = FD_RST;
		end else if (in_attempt) begin
			fd_d = fd_step_f(fd_q);
		end
	end

	// register the fault distance counter
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			fd_q <= FD_RST;
		end else begin
			fd_q <= fd_d;
		end
	end

	// transmitter on: enabled only from idle, so a frame is never started
	// half way; a starve switches it off until enable is seen again
	always_comb begin
		transmitter_on_d = transmitter_on_q;
		if (end_starve) begin
			transmitter_on_d = 1'h0;
		end else if (TX_ENABLE && !transmitter_on_q && in_idle) begin
			transmitter_on_d = 1'h1;
		end
	end

	// register the transmitter state
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			transmitter_on_q <= 1'h0;
		end else begin
			transmitter_on_q <= transmitter_on_d;
		end
	end

	// status word: cleared when the next frame is taken, which is how the
	// host clears its flags; bits only ever set while an attempt runs
	always_comb begin
		word_d = word_q;
		if (take_frame) begin
			word_d = STATUS_RST;
		end
		if (in_attempt) begin
			if (!RECEIVE_CARRIER_INPUT) begin
				word_d[CARRIER_LOSS_FLAG_BIT] = 1'h1;
			end
			if (chain_break) begin
				word_d[CBE_BIT] = 1'h1;
			end
			if (end_starve) begin
				word_d[FSE_BIT] = 1'h1;
			end
			if (end_late) begin
				word_d[LATE_COLLISION_FLAG_BIT] = 1'h1;
			end
			if (hit_coll) begin
				word_d[FD_MSB:0] = fd_q;
			end
			if (end_spent) begin
				word_d[RTX_BIT] = 1'h1;
			end
		end
		word_d[RSV_BIT] = 1'h0;
	end

	// register the status word
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			word_q <= STATUS_RST;
		end else begin
			word_q <= word_d;
		end
	end

	// one-cycle pulses: abort with the ending edge, write and done one later
	always_comb begin
		retry_d = do_retry;
		abort_d = end_starve || end_late || end_spent;
		wr_d    = in_finish && err_any_f(word_q);
		done_d  = in_finish;
	end

	// register the pulses
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			wr_q    <= 1'h0;
			done_q  <= 1'h0;
			retry_q <= 1'h0;
			abort_q <= 1'h0;
		end else begin
			wr_q    <= wr_d;
			done_q  <= done_d;
			retry_q <= retry_d;
			abort_q <= abort_d;
		end
	end

	// outputs straight from flops
	assign TRANSMITTER_ON       = transmitter_on_q;
	assign RETRY_REQ            = retry_q;
	assign ABORT_FRAME          = abort_q;
	assign TX_ERROR_STATUS_WORD = word_q;
	assign STATUS_WRITE         = wr_q;
	assign FRAME_DONE           = done_q;

endmodule // tdes_status
`default_nettype wire

// ---- tb/tdes_props.sv ----
// assertion checker for the transmit error status block
`timescale 1ns/100ps
`default_nettype none
module tdes_props
	import tdes_pkg::*;
(
	// clock and reset
	input wire logic        CORE_CLK,
	input wire logic        RST_B,
	// watched signals
	input wire logic        RETRY_DISABLE,
	input wire logic        TRANSMITTER_ON,
	input wire logic        RETRY_REQ,
	input wire logic        ABORT_FRAME,
	input wire logic [15:0] TX_ERROR_STATUS_WORD,
	input wire logic        STATUS_WRITE,
	input wire logic        FRAME_DONE
);
	// one clock domain, so one clocking and one reset guard serve all
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RST_B);
	wire logic [15:0] w = TX_ERROR_STATUS_WORD;
	a_rsv_zero: assert property (!w[13]) else $error("rsv set");
	a_break_starve: assert property (w[15] |-> w[14]) else $error("no starve");
	a_break_off: assert property ($rose(w[15]) |-> ##[0:1] !TRANSMITTER_ON) else $error("on");
	a_starve_off: assert property ($rose(w[14]) |-> ##[0:1] !TRANSMITTER_ON) else $error("on");
	a_late_noretry: assert property ($rose(w[12]) |-> ABORT_FRAME && !RETRY_REQ) else $error("lc");
	a_write_err: assert property (STATUS_WRITE |-> |w[15:10]) else $error("wr");
	a_abort_write: assert property (ABORT_FRAME |=> STATUS_WRITE && FRAME_DONE) else $error("ab");
	a_nodis_retry: assert property (RETRY_DISABLE && $past(RETRY_DISABLE) |-> !RETRY_REQ) else $error("rr");
endmodule // tdes_props
bind tdes_status tdes_props u_props (.CORE_CLK(CORE_CLK), .RST_B(RST_B),
	.RETRY_DISABLE(RETRY_DISABLE), .TRANSMITTER_ON(TRANSMITTER_ON), .RETRY_REQ(RETRY_REQ),
	.ABORT_FRAME(ABORT_FRAME), .TX_ERROR_STATUS_WORD(TX_ERROR_STATUS_WORD),
	.STATUS_WRITE(STATUS_WRITE), .FRAME_DONE(FRAME_DONE));
`default_nettype wire

// ---- tb/tdes_host.sv ----
// host model: descriptor chain state and host view of the status word
`timescale 1ns/100ps
`default_nettype none
module tdes_host
	import tdes_pkg::*;
(
	// descriptor bits, status word and loopback mode
	input  wire logic [3:0]  DESC,
	input  wire logic [15:0] WORD,
	input  wire logic        LOOPBACK,
	// chain view and the flags the host trusts
	output var tdes_chain_t  CHAIN,
	output logic [9:0]       FD_SEEN,
	output logic             BREAK_SEEN,
	output logic             CARRIER_SEEN
);
	// descriptor bits come straight from shared memory
	assign CHAIN = tdes_chain_t'(DESC);
	// distance is junk unless the retry flag stands beside it
	assign FD_SEEN = WORD[10] ? WORD[9:0] : 10'h000;
	// a chain break beside a late collision or spent retries is not believed
	assign BREAK_SEEN = WORD[15] && !WORD[12] && !WORD[10];
	// loopback never feeds the carrier input, so its loss means nothing there
	assign CARRIER_SEEN = WORD[11] && !LOOPBACK;
endmodule // tdes_host
`default_nettype wire

// ---- tb/tdes_status_tb.sv ----
// self-checking bench for the transmit error status block
`timescale 1ns/100ps
`default_nettype none
module tdes_status_tb;
	import tdes_pkg::*;
	logic core_clk = 0, rst_b = 0, tx_en = 0, rd = 0, req = 0, car = 1, lpbk = 0, ab_seen = 0;
	logic [3:0] att = 4'h0, desc = 4'hE;
	tdes_chain_t chain;
	logic transmitter_on, rreq, abrt, wr, fdone, brk_seen, car_seen;
	logic [15:0] word;
	logic [9:0] fd_seen;
	int n_fail = 0, checks = 0, n_rr;
	// rows: chain, event, retry disable, carrier drop, expected word
	logic [31:0] rows [7] = '{32'hE4100403, 32'hE6001000, 32'h90004000, 32'hE1000000,
		32'h3000C000, 32'h5000C000, 32'hE1010800};
	tdes_status uut (.CORE_CLK(core_clk), .RST_B(rst_b), .TX_ENABLE(tx_en), .RETRY_DISABLE(rd),
		.FRAME_REQ(req), .ATTEMPT(att), .CHAIN(chain), .RECEIVE_CARRIER_INPUT(car),
		.TRANSMITTER_ON(transmitter_on), .RETRY_REQ(rreq), .ABORT_FRAME(abrt),
		.TX_ERROR_STATUS_WORD(word), .STATUS_WRITE(wr), .FRAME_DONE(fdone));
	tdes_host host (.DESC(desc), .WORD(word), .LOOPBACK(lpbk), .CHAIN(chain), .FD_SEEN(fd_seen),
		.BREAK_SEEN(brk_seen), .CARRIER_SEEN(car_seen));
	task automatic chk(input string nm, input logic [15:0] got, exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// toggling enable revives the transmitter after a starve
	task automatic go(input logic r);
		tx_en = 0;
		tick(2);
		tx_en = 1;
		rd = r;
		for (int k = 0; k < 8 && transmitter_on !== 1'b1; k++) tick(1);
		req = 1;
		tick(1);
		req = 0;
	endtask
	task automatic try(input logic [3:0] ev, ch, input int gap);
		att = 4'h8;
		tick(1);
		att = 4'h0;
		tick(gap - 1);
		att = ev;
		desc = ch;
		tick(1);
		// retry and abort are one-cycle pulses: take them while they stand
		ab_seen = abrt;
		n_rr += rreq;
		att = 4'h0;
		desc = 4'hE;
		car = 1;
		tick(1);
	endtask
	task automatic wrap_up();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		forever #2.5 core_clk = ~core_clk;
	end
	// about 150 cycles are needed; this is 4000 cycles, over twenty times that
	initial begin
		#20000;
		n_fail++;
		wrap_up();
	end
	initial begin
		tick(11);
		chk("rst word", word, 16'h0000);
		tick(1);
		rst_b = 1;
		foreach (rows[i]) begin
			car = !rows[i][16];
			go(rows[i][20]);
			try(rows[i][27:24], rows[i][31:28], 4);
			chk("word", word, rows[i][15:0]);
			chk("tx on", transmitter_on, !rows[i][14]);
			chk("write", wr, |rows[i][15:10]);
			chk("done", fdone, 1);
			chk("abort", ab_seen, |{rows[i][15:14], rows[i][12], rows[i][10]});
			chk("break", brk_seen, rows[i][15]);
			chk("carrier", car_seen, rows[i][11]);
			tick(1);
		end
		// the carrier loss of the last row still stands: loopback hides it
		lpbk = 1;
		tick(1);
		chk("loop carrier", car_seen, 0);
		lpbk = 0;
		// a stale count would carry over from earlier frames instead of restarting
		go(1'b0);
		n_rr = 0;
		repeat (RETRY_MAX) begin
			try(4'h4, 4'hE, 2);
			n_rr += rreq;
		end
		chk("retries", n_rr, 15);
		chk("word", word, 16'h0401);
		chk("fd", fd_seen, 1);
		wrap_up();
	end
endmodule // tdes_status_tb
`default_nettype wire
